/* wtu_pkg.sv */
// Shared constants and types of the watchdog timer unit
package wtu_pkg;

  // Special-function register address and layout of watchdog_control
  localparam logic [7:0] WTU_CTRL_ADDR  = 8'hc0;
  localparam logic [7:0] WTU_CTRL_RESET = 8'h10;
  localparam int         WTU_PRE_LSB    = 4;
  localparam int         WTU_IRQ_SEL    = 3;
  localparam int         WTU_FLAG       = 2;
  localparam int         WTU_ARM        = 1;
  localparam int         WTU_UNLOCK     = 0;

  // Prescale codes: 0..7 timed, 8 immediate reset, above 8 reserved
  localparam logic [3:0] WTU_PRE_MAX_TIMED = 4'h7;
  localparam logic [3:0] WTU_PRE_IMMEDIATE = 4'h8;

  // Timebase: 2^9 crystal periods at 32.768 kHz, doubled per prescale step
  localparam int         WTU_XTAL_HZ     = 32768;
  localparam int         WTU_BASE_SHIFT  = 9;
  localparam int         WTU_CNT_W       = 16;
  localparam logic [16:0] WTU_BASE_PERIOD = 17'h00200;

  // Instruction ends counted from setting the unlock bit: its own, then one more
  localparam logic [1:0] WTU_UNLOCK_SPAN = 2'h2;
  localparam logic [1:0] WTU_UNLOCK_OPEN = 2'h1;

  // One special-function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [7:0] wdata;
  } wtu_sfr_req_t;

  typedef enum logic [1:0] {
    WTU_IDLE,
    WTU_TIMING,
    WTU_IRQ_WAIT
  } wtu_state_t;

endpackage

/* wtu_xtal_tick.sv */
// Crystal-clock edge detector producing one core-cycle tick per crystal period
`timescale 1ns/10ps
`default_nettype none
module wtu_xtal_tick
  import wtu_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic xtal_clk,
  output logic      tick
);

  logic xtal_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_prev <= 1'b0;
    end else begin
      xtal_prev <= xtal_clk;
    end
  end

  // Rising crystal edge only; the core clock is far faster than 32 kHz
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= xtal_clk & ~xtal_prev;
    end
  end

endmodule
`default_nettype wire

/* wtu_timeout_cnt.sv */
// Timeout counter advanced by crystal ticks, limit chosen by the prescale code
`timescale 1ns/10ps
`default_nettype none
module wtu_timeout_cnt
  import wtu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [3:0] pre,
  output logic            expire
);

  logic [WTU_CNT_W-1:0] count;
  logic [WTU_CNT_W-1:0] last_count;

  function automatic logic [WTU_CNT_W-1:0] wtu_last(input logic [3:0] p);
    logic [16:0] span;
    span = WTU_BASE_PERIOD << p[2:0];
    return WTU_CNT_W'(span - 17'h00001);
  endfunction

  assign last_count = wtu_last(pre); // R05

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (restart || !run) begin
      count <= '0; // R12
    end else if (tick) begin
      if (count == last_count) begin
        count <= '0; // R09
      end else begin
        count <= count + 1'b1; // R03
      end
    end
  end

  assign expire = run && !restart && tick && (count == last_count);

endmodule
`default_nettype wire

/* watchdog_timer_unit.sv */
// Watchdog timer unit: control register, write unlock, timeout and responses
//
// What this block does
// R01: Clearing the arm bit stops supervision; no timeout reset or interrupt follows.
// R02: While armed, missing a re-arm before timeout raises reset or interrupt.
// R03: The counter advances on the 32 kHz crystal clock, not the core clock.
// R04: A control write counts only when the unlock sequence directly precedes it.
// R05: Timeout is 2^prescale times 2^9 crystal periods for codes 0 to 7.
// R06: Code 8 resets immediately; codes above 8 are reserved for software.
// R07: With interrupt select set, expiry raises an interrupt instead of reset.
// R08: The watchdog interrupt ignores the global mask and has fixed high priority.
// R09: In interrupt mode the prescale sets the period between repeated interrupts.
// R10: Each timeout sets the timeout status flag.
// R11: The flag clears only by software zero or hardware reset, not watchdog reset.
// R12: Setting the arm bit enables the watchdog and restarts its counters.
// R13: Arm clears on software zero, watchdog reset, hardware reset or supply alarm.
// R14: Software masks interrupts, sets unlock, then writes control in the next instruction.
// R15: Unlock permission expires after the one instruction following its setting.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_unit
  import wtu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire wtu_sfr_req_t sfr_req,
  input  wire logic         instr_done,
  input  wire logic         xtal_clk,
  input  wire logic         supply_monitor_irq,
  input  wire logic         irq_ack,
  output logic [7:0]        sfr_rdata,
  output logic              sys_reset_req,
  output logic              timeout_irq,
  output logic              timeout_irq_high_prio,
  output logic [3:0]        timeout_prescale,
  output logic              watchdog_arm
);

  // Control fields
  logic       timeout_irq_select;
  logic       timeout_flag;
  logic [1:0] unlock_cnt;
  logic       write_unlock;

  // Access decoding
  logic       hit;
  logic       byte_hit;
  logic       bit_hit;
  logic       set_unlock;
  logic       ctrl_wr_ok;
  logic [7:0] cur_byte;
  logic [7:0] new_byte;
  logic [7:0] touched;

  // Timeout machinery
  logic       tick;
  logic       kick;
  logic       run;
  logic       restart;
  logic       expire;
  logic       immediate;
  logic       wd_reset;
  logic       wd_irq_event;
  wtu_state_t state;
  wtu_state_t next_state;

  // Byte as the access leaves it: one bit replaced for a bit write, wdata whole for a byte write
  function automatic logic [7:0] wtu_merge(input logic [7:0] cur, input logic bw,
                                           input logic [2:0] idx, input logic val,
                                           input logic [7:0] wd);
    logic [7:0] r;
    r = cur;
    if (bw) begin
      r[idx] = val;
    end else begin
      r = wd;
    end
    return r;
  endfunction

  // Which bits an access really changes
  function automatic logic [7:0] wtu_mask(input logic bw, input logic [2:0] idx);
    logic [7:0] m;
    m = 8'hff;
    if (bw) begin
      m = 8'h01 << idx;
    end
    return m;
  endfunction

  assign hit      = (sfr_req.addr == WTU_CTRL_ADDR);
  assign byte_hit = hit && sfr_req.wr;
  assign bit_hit  = hit && sfr_req.bit_wr;

  assign cur_byte = {timeout_prescale, timeout_irq_select, timeout_flag, watchdog_arm, write_unlock};
  assign new_byte = wtu_merge(cur_byte, sfr_req.bit_wr, sfr_req.bit_idx, sfr_req.bit_val, sfr_req.wdata);
  assign touched  = wtu_mask(sfr_req.bit_wr, sfr_req.bit_idx);

  // Setting the unlock bit alone needs no permission
  assign set_unlock = bit_hit && (sfr_req.bit_idx == 3'(WTU_UNLOCK)) && sfr_req.bit_val;

  // Any other write lands only inside the one-instruction window
  assign ctrl_wr_ok = (byte_hit || (bit_hit && !set_unlock)) && (unlock_cnt == WTU_UNLOCK_OPEN); // R04

  assign write_unlock = (unlock_cnt != 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_cnt <= 2'h0;
    end else if (set_unlock) begin
      unlock_cnt <= WTU_UNLOCK_SPAN;
    end else if (ctrl_wr_ok) begin
      unlock_cnt <= 2'h0;
    end else if (instr_done && unlock_cnt != 2'h0) begin
      unlock_cnt <= unlock_cnt - 2'h1; // R15
    end
  end

  // Prescale and interrupt select
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_prescale <= WTU_CTRL_RESET[7:WTU_PRE_LSB];
    end else if (ctrl_wr_ok && (touched[7:WTU_PRE_LSB] != 4'h0)) begin
      timeout_prescale <= new_byte[7:WTU_PRE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_irq_select <= WTU_CTRL_RESET[WTU_IRQ_SEL];
    end else if (ctrl_wr_ok && touched[WTU_IRQ_SEL]) begin
      timeout_irq_select <= new_byte[WTU_IRQ_SEL];
    end
  end

  // Kick: any accepted write of one to the arm bit, even if already set
  assign kick = ctrl_wr_ok && touched[WTU_ARM] && new_byte[WTU_ARM]; // R12

  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_arm <= WTU_CTRL_RESET[WTU_ARM]; // R13
    end else if (supply_monitor_irq || wd_reset) begin
      watchdog_arm <= 1'b0; // R13
    end else if (ctrl_wr_ok && touched[WTU_ARM]) begin
      watchdog_arm <= new_byte[WTU_ARM]; // R01
    end
  end

  // Flag: timeout sets it and wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_flag <= WTU_CTRL_RESET[WTU_FLAG]; // R11
    end else if (expire || immediate) begin
      timeout_flag <= 1'b1; // R10
    end else if (ctrl_wr_ok && touched[WTU_FLAG] && !new_byte[WTU_FLAG]) begin
      timeout_flag <= 1'b0; // R11
    end
  end

  assign sfr_rdata = cur_byte;

  // Timeout counting
  assign run     = watchdog_arm && (timeout_prescale <= WTU_PRE_MAX_TIMED); // R06
  assign restart = kick || !watchdog_arm;

  wtu_xtal_tick wtu_xtal_tick_inst (
    .clk      (clk),
    .rst      (rst),
    .xtal_clk (xtal_clk),
    .tick     (tick)
  );

  wtu_timeout_cnt wtu_timeout_cnt_inst (
    .clk     (clk),
    .rst     (rst),
    .restart (restart),
    .run     (run),
    .tick    (tick),
    .pre     (timeout_prescale),
    .expire  (expire)
  );

  // Code 8 fires at once while armed; reserved codes simply never time out
  assign immediate = watchdog_arm && (timeout_prescale == WTU_PRE_IMMEDIATE); // R06

  assign wd_reset     = immediate || (expire && !timeout_irq_select); // R02
  assign wd_irq_event = expire && timeout_irq_select; // R07

  // Response tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= WTU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      WTU_IDLE: begin
        if (watchdog_arm) begin
          next_state = WTU_TIMING;
        end
      end
      WTU_TIMING: begin
        if (wd_irq_event) begin
          next_state = WTU_IRQ_WAIT;
        end else if (!watchdog_arm) begin
          next_state = WTU_IDLE;
        end
      end
      WTU_IRQ_WAIT: begin
        // Counter keeps running, so a slow handler still sees the next period
        if (irq_ack && !wd_irq_event) begin
          next_state = watchdog_arm ? WTU_TIMING : WTU_IDLE;
        end
      end
      default: begin
        next_state = WTU_IDLE;
      end
    endcase
  end

  // Reset request: single pulse, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= wd_reset; // R02
    end
  end

  // Interrupt request held until acknowledged, not gated by the global mask
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_irq <= 1'b0;
    end else if (wd_irq_event) begin
      timeout_irq <= 1'b1; // R08
    end else if (irq_ack || state == WTU_IDLE) begin
      timeout_irq <= 1'b0;
    end
  end

  // Fixed high priority marker for the interrupt controller
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_irq_high_prio <= 1'b0;
    end else begin
      timeout_irq_high_prio <= 1'b1; // R08
    end
  end

endmodule
`default_nettype wire

/* wtu_props.sv */
// Port-level checker of the watchdog timer unit
`timescale 1ns/10ps
`default_nettype none
module wtu_props
  import wtu_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire wtu_sfr_req_t sfr_req,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         sys_reset_req,
  input wire logic         timeout_irq,
  input wire logic         timeout_irq_high_prio,
  input wire logic [3:0]   timeout_prescale,
  input wire logic         watchdog_arm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire ctl_wr = sfr_req.addr == WTU_CTRL_ADDR && (sfr_req.wr || sfr_req.bit_wr);
  // Unlock bit reads back the pending or open window
  wire ok_wr  = ctl_wr && sfr_rdata[WTU_UNLOCK];

  a_reset_needs_arm: assert property (sys_reset_req |-> $past(watchdog_arm))
    else $error("reset request while not armed");
  a_reset_one_pulse: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  a_reset_disarms: assert property (sys_reset_req |-> !watchdog_arm && sfr_rdata[WTU_FLAG])
    else $error("reset without disarm or flag");
  a_irq_cause: assert property ($rose(timeout_irq) |->
    watchdog_arm && sfr_rdata[WTU_IRQ_SEL] && sfr_rdata[WTU_FLAG])
    else $error("interrupt without select, arm or flag");
  a_flag_sticky: assert property ($fell(sfr_rdata[WTU_FLAG]) |-> $past(ctl_wr))
    else $error("flag cleared without a write");
  a_pre_unlocked: assert property ($changed(timeout_prescale) |-> $past(ok_wr))
    else $error("prescale changed without unlocked write");
  a_prio_fixed: assert property (!$past(rst) |-> timeout_irq_high_prio)
    else $error("interrupt priority marker low");
  a_immediate_reset: assert property (watchdog_arm && timeout_prescale == WTU_PRE_IMMEDIATE
    |-> ##[1:2] sys_reset_req)
    else $error("no immediate reset for code 8");
endmodule

bind watchdog_timer_unit wtu_props wtu_props_inst (.clk(clk), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .sys_reset_req(sys_reset_req), .timeout_irq(timeout_irq),
  .timeout_irq_high_prio(timeout_irq_high_prio), .timeout_prescale(timeout_prescale),
  .watchdog_arm(watchdog_arm));
`default_nettype wire

/* watchdog_timer_unit_test.sv */
// Self-checking bench of the watchdog timer unit
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_unit_test
  import wtu_pkg::*;
;
  logic         clk = 0, rst = 1, instr_done = 0, supply_monitor_irq = 0, irq_ack = 0;
  wtu_sfr_req_t sfr_req = '0;
  logic [1:0]   xc = 0;
  logic [7:0]   sfr_rdata;
  logic         sys_reset_req, timeout_irq, timeout_irq_high_prio, watchdog_arm;
  logic [3:0]   timeout_prescale;
  int           mismatches = 0, n_checks = 0, n_rst = 0, n;

  initial forever #2 clk = ~clk;
  // Crystal sped up to one period per 4 core cycles to keep runs short
  always @(posedge clk) begin
    xc <= xc + 2'h1;
    if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
  end

  watchdog_timer_unit watchdog_timer_unit_inst (.clk(clk), .rst(rst), .sfr_req(sfr_req),
    .instr_done(instr_done), .xtal_clk(xc[1]), .supply_monitor_irq(supply_monitor_irq),
    .irq_ack(irq_ack), .sfr_rdata(sfr_rdata), .sys_reset_req(sys_reset_req),
    .timeout_irq(timeout_irq), .timeout_irq_high_prio(timeout_irq_high_prio),
    .timeout_prescale(timeout_prescale), .watchdog_arm(watchdog_arm));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Unlock (unl 1), unlock then a stray instruction (unl 2), then one access
  task automatic op(input logic b, input logic [2:0] i, input logic [7:0] d, input int unl);
    if (unl > 0) begin
      @(posedge clk) sfr_req <= '{WTU_CTRL_ADDR, 1'b0, 1'b1, 3'h0, 1'b1, 8'h00};
      @(posedge clk) begin
        sfr_req <= '0;
        instr_done <= 1'b1;
      end
      if (unl > 1) @(posedge clk);
    end
    @(posedge clk) begin
      sfr_req <= '{WTU_CTRL_ADDR, ~b, b, i, d[0], d};
      instr_done <= 1'b1;
    end
    @(posedge clk) begin
      sfr_req <= '0;
      instr_done <= 1'b0;
    end
    @(negedge clk);
  endtask

  task automatic waitfor(input logic w);
    n = 0;
    while (((w ? timeout_irq : sys_reset_req) !== 1'b1) && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    #200000;
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk(sfr_rdata, WTU_CTRL_RESET);
    chk({7'h0, timeout_irq_high_prio}, 8'h01);
    op(1'b0, 3'h0, 8'h02, 0);
    chk(sfr_rdata, 8'h10);
    op(1'b0, 3'h0, 8'h02, 2);
    chk(sfr_rdata, 8'h10);
    op(1'b0, 3'h0, 8'h02, 1);
    chk(sfr_rdata, 8'h02);
    waitfor(1'b0);
    chk(8'(n >= 2040 && n <= 2060), 8'h01);
    chk(sfr_rdata, 8'h04);
    op(1'b0, 3'h0, 8'h02, 1);
    chk(sfr_rdata, 8'h02);
    // Kick after 1500 of the 2048 cycles so the first period never completes
    repeat (1500) @(negedge clk);
    op(1'b0, 3'h0, 8'h02, 1);
    repeat (1500) @(negedge clk);
    op(1'b1, 3'h1, 8'h00, 1);
    chk(sfr_rdata, 8'h00);
    repeat (2500) @(negedge clk);
    chk(n_rst[7:0], 8'h01);
    op(1'b0, 3'h0, 8'h1a, 1);
    chk({timeout_prescale, 3'h0, watchdog_arm}, 8'h11);
    repeat (2) begin
      waitfor(1'b1);
      chk(8'(n >= 4085 && n <= 4110), 8'h01);
      chk(sfr_rdata, 8'h1e);
      @(posedge clk) irq_ack <= 1'b1;
      @(posedge clk) irq_ack <= 1'b0;
      @(negedge clk) chk({7'h0, timeout_irq}, 8'h00);
    end
    chk(n_rst[7:0], 8'h01);
    op(1'b0, 3'h0, 8'h02, 1);
    @(posedge clk) supply_monitor_irq <= 1'b1;
    @(posedge clk) supply_monitor_irq <= 1'b0;
    @(negedge clk) chk(sfr_rdata, 8'h00);
    op(1'b0, 3'h0, 8'h82, 1);
    waitfor(1'b0);
    chk(8'(n < 4), 8'h01);
    chk(sfr_rdata, 8'h84);
    chk({timeout_prescale, 3'h0, watchdog_arm}, 8'h80);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) chk(sfr_rdata, WTU_CTRL_RESET);
    finish_test;
  end
endmodule
`default_nettype wire
